// ### charger_irq_pkg.sv
package charger_irq_pkg;

  // Register addresses
  localparam logic [7:0] FAULT_FLAGS_SECONDARY_ADDR = 8'h27;
  localparam logic [7:0] EVENT_MASK_FIRST_ADDR = 8'h28;
  localparam logic [7:0] EVENT_MASK_SECOND_ADDR = 8'h29;

  // Reset values
  localparam logic [7:0] FAULT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;

  // Fault flag bit positions
  localparam int SYS_SHORT_BIT = 7;
  localparam int SYS_OVP_BIT = 6;
  localparam int REV_OVP_BIT = 5;
  localparam int REV_UVP_BIT = 4;
  localparam int THERM_SHUT_BIT = 2;
  localparam logic [7:0] FAULT_FLAGS_USED = 8'hf4;

  // Second mask writable bits, bits 5 and 3 reserved
  localparam logic [7:0] EVENT_MASK_SECOND_USED = 8'hd7;

  // Interrupt pulse width in ns and cycles at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int IRQ_PULSE_NS = 256000;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;

  // Fault condition inputs
  typedef struct packed {
    logic systemRailShort;
    logic systemRailOvervolt;
    logic reverseOutputOvervolt;
    logic reverseOutputUndervolt;
    logic dieThermalShutdown;
  } fault_cond_type;

  // Charger event strobes, one bit per mask position
  typedef struct packed {
    logic [7:0] firstGroup;
    logic [7:0] secondGroup;
  } charger_event_type;

  // Register access from the serial bus engine
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_access_type;

  // Pulse FSM states
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_LOW = 2'b01,
    PULSE_GAP = 2'b11
  } pulse_state_type;

endpackage

// ### fault_flag_latch.sv
`timescale 1ns/100ps
// Sticky fault flags, cleared on host read; a new event wins over the read
module fault_flag_latch
  import charger_irq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire fault_cond_type faultCond,
  input wire logic clearOnRead,
  output logic [7:0] flags
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flags;
    logic [4:0] prevCond;
  } latch_state_type;

  latch_state_type state_reg;
  latch_state_type state_next;
  logic [4:0] condVec; // Packed condition levels
  logic [7:0] setVec; // Rising edges mapped onto flag bits

  assign condVec = faultCond;
  assign flags = state_reg.flags;

  // Rising-edge detect and set/clear priority
  always_comb begin
    setVec = 8'h00;
    setVec[SYS_SHORT_BIT] = condVec[4] & ~state_reg.prevCond[4];
    setVec[SYS_OVP_BIT] = condVec[3] & ~state_reg.prevCond[3];
    setVec[REV_OVP_BIT] = condVec[2] & ~state_reg.prevCond[2];
    setVec[REV_UVP_BIT] = condVec[1] & ~state_reg.prevCond[1];
    setVec[THERM_SHUT_BIT] = condVec[0] & ~state_reg.prevCond[0];
    state_next = state_reg;
    state_next.prevCond = condVec;
    if (clearOnRead) begin
      state_next.flags = 8'h00;
    end
    state_next.flags = (state_next.flags | setVec) & FAULT_FLAGS_USED;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
    (state_reg.flags[SYS_SHORT_BIT] && !clearOnRead) |=> state_reg.flags[SYS_SHORT_BIT])
    else $error("fault flag dropped without read");
  a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
    (condVec[0] && !state_reg.prevCond[0]) |=> state_reg.flags[THERM_SHUT_BIT])
    else $error("thermal flag not set");
  a_flag_reserved: assert property (@(posedge mclk) disable iff (rst)
    (state_reg.flags & ~FAULT_FLAGS_USED) == 8'h00)
    else $error("reserved fault bit set");

endmodule

// ### irq_pulse_gen.sv
`timescale 1ns/100ps
// Fixed-width active-low pulses; requests arriving during a pulse collapse into one pending flag
module irq_pulse_gen
  import charger_irq_pkg::*;
#(
  parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic request,
  output logic irqN
);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin
      $error("pulse width out of range");
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pulse_state_type fsm;
    logic [15:0] count;
    logic pending;
    logic irqN;
  } pulse_reg_type;

  pulse_reg_type state_reg;
  pulse_reg_type state_next;

  assign irqN = state_reg.irqN;

  // Pulse sequencing: low for PULSE_CYCLES, then high through PULSE_GAP and PULSE_IDLE, at least two cycles
  always_comb begin
    state_next = state_reg;
    if (request) begin
      state_next.pending = 1'b1;
    end
    unique case (state_reg.fsm)
      PULSE_IDLE: begin
        if (request || state_reg.pending) begin
          state_next.fsm = PULSE_LOW;
          state_next.irqN = 1'b0;
          state_next.count = 16'(PULSE_CYCLES - 1);
          state_next.pending = 1'b0;
        end
      end
      PULSE_LOW: begin
        if (state_reg.count == 16'h0000) begin
          state_next.fsm = PULSE_GAP;
          state_next.irqN = 1'b1;
        end else begin
          state_next.count = state_reg.count - 16'h0001;
        end
      end
      PULSE_GAP: begin
        state_next.fsm = PULSE_IDLE;
      end
      default: begin
        state_next.fsm = PULSE_IDLE;
        state_next.irqN = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '{fsm: PULSE_IDLE, count: 16'h0000, pending: 1'b0, irqN: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  a_pulse_start: assert property (@(posedge mclk) disable iff (rst)
    (request && state_reg.fsm == PULSE_IDLE) |=> !irqN)
    else $error("pulse did not start");
  a_pulse_end: assert property (@(posedge mclk) disable iff (rst)
    (state_reg.fsm == PULSE_LOW && state_reg.count == 16'h0000) |=> irqN)
    else $error("pulse did not end");
  c_pulse_seen: cover property (@(posedge mclk) disable iff (rst) $fell(irqN));

endmodule

// ### charger_irq_ctrl.sv
`timescale 1ns/100ps
module charger_irq_ctrl
  import charger_irq_pkg::*;
#(
  parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic regResetCmd,
  input wire reg_access_type regAccess,
  input wire fault_cond_type faultCondPin,
  input wire charger_event_type chargerEvent,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic irqN
);

  // ------------------------------------------------------------
  // Input synchronisers for analog fault detectors
  // ------------------------------------------------------------
  fault_cond_type faultMeta_reg; // First stage, read only by second
  fault_cond_type faultSync_reg; // Second stage, safe to use

  // Two-flop synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      faultMeta_reg <= '0;
      faultSync_reg <= '0;
    end else begin
      faultMeta_reg <= faultCondPin;
      faultSync_reg <= faultMeta_reg;
    end
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] maskFirst;
    logic [7:0] maskSecond;
    logic [7:0] rdData;
    logic rdValid;
    logic irqRequest;
  } ctrl_state_type;

  ctrl_state_type state_reg;
  ctrl_state_type state_next;
  logic [7:0] faultFlags; // Sticky fault flags
  logic faultRead; // Host reads the fault register
  logic [7:0] passFirst; // Unmasked first-group events
  logic [7:0] passSecond; // Unmasked second-group events

  // Address match helper
  function automatic logic hit(input reg_access_type acc, input logic [7:0] addr);
    return acc.addr == addr;
  endfunction

  assign faultRead = regAccess.rdStb && hit(regAccess, FAULT_FLAGS_SECONDARY_ADDR);

  // ------------------------------------------------------------
  // Fault flag register
  // ------------------------------------------------------------
  fault_flag_latch u_flags (
    .mclk(mclk),
    .rst(rst),
    .faultCond(faultSync_reg),
    .clearOnRead(faultRead),
    .flags(faultFlags)
  );

  // ------------------------------------------------------------
  // Event masking
  // ------------------------------------------------------------
  // Bit k of each event group is gated by bit k of its mask
  always_comb begin
    passFirst = chargerEvent.firstGroup & ~state_reg.maskFirst;
    // Watchdog, weak source, power good and presence bits
    passSecond = chargerEvent.secondGroup & ~state_reg.maskSecond
      & EVENT_MASK_SECOND_USED;
  end

  // ------------------------------------------------------------
  // Register file and read path
  // ------------------------------------------------------------
  // Writes, reads and interrupt request
  always_comb begin
    state_next = state_reg;
    state_next.rdValid = regAccess.rdStb;
    state_next.irqRequest = |{passFirst, passSecond};
    // Host write to a mask register
    if (regAccess.wrStb) begin
      if (hit(regAccess, EVENT_MASK_FIRST_ADDR)) begin
        state_next.maskFirst = regAccess.wrData;
      end else if (hit(regAccess, EVENT_MASK_SECOND_ADDR)) begin
        state_next.maskSecond = regAccess.wrData & EVENT_MASK_SECOND_USED;
      end
    end
    // Register reset command clears both masks
    if (regResetCmd) begin
      state_next.maskFirst = EVENT_MASK_RESET;
      state_next.maskSecond = EVENT_MASK_RESET;
    end
    // Read mux, unmapped addresses return zero
    if (regAccess.rdStb) begin
      if (hit(regAccess, FAULT_FLAGS_SECONDARY_ADDR)) begin
        state_next.rdData = faultFlags;
      end else if (hit(regAccess, EVENT_MASK_FIRST_ADDR)) begin
        state_next.rdData = state_reg.maskFirst;
      end else if (hit(regAccess, EVENT_MASK_SECOND_ADDR)) begin
        state_next.rdData = state_reg.maskSecond;
      end else begin
        state_next.rdData = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '{maskFirst: EVENT_MASK_RESET, maskSecond: EVENT_MASK_RESET,
                     rdData: 8'h00, rdValid: 1'b0, irqRequest: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData = state_reg.rdData;
  assign rdValid = state_reg.rdValid;

  // ------------------------------------------------------------
  // Interrupt pulse output
  // ------------------------------------------------------------
  irq_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .mclk(mclk),
    .rst(rst),
    .request(state_reg.irqRequest),
    .irqN(irqN)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_mask_blocks: assert property (@(posedge mclk) disable iff (rst)
    (chargerEvent.firstGroup != 8'h00 && (chargerEvent.firstGroup & ~state_reg.maskFirst) == 8'h00
     && (chargerEvent.secondGroup & ~state_reg.maskSecond & EVENT_MASK_SECOND_USED) == 8'h00)
    |=> !state_reg.irqRequest)
    else $error("masked event raised request");
  a_mask_passes: assert property (@(posedge mclk) disable iff (rst)
    ((chargerEvent.firstGroup & ~state_reg.maskFirst) != 8'h00) |=> state_reg.irqRequest)
    else $error("unmasked event lost");
  a_mask_reset: assert property (@(posedge mclk) disable iff (rst)
    regResetCmd |=> (state_reg.maskFirst == 8'h00 && state_reg.maskSecond == 8'h00))
    else $error("register reset missed masks");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (state_reg.maskSecond & ~EVENT_MASK_SECOND_USED) == 8'h00)
    else $error("reserved mask bit set");
  a_read_fault: assert property (@(posedge mclk) disable iff (rst)
    faultRead |=> (rdValid && rdData == $past(faultFlags)))
    else $error("fault read data wrong");
  a_mask_write: assert property (@(posedge mclk) disable iff (rst)
    (regAccess.wrStb && hit(regAccess, EVENT_MASK_FIRST_ADDR) && !regResetCmd)
    |=> state_reg.maskFirst == $past(regAccess.wrData))
    else $error("first mask write lost");
  c_fault_read: cover property (@(posedge mclk) disable iff (rst) faultRead && faultFlags != 8'h00);
  c_mask_write: cover property (@(posedge mclk) disable iff (rst)
    regAccess.wrStb && hit(regAccess, EVENT_MASK_SECOND_ADDR));
  c_irq_req: cover property (@(posedge mclk) disable iff (rst) state_reg.irqRequest);

endmodule

// ### host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the register access port
// ----------------------------------------
module host_model
  import charger_irq_pkg::*;
(
  input wire logic mclk,
  output reg_access_type regAccess,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  // Idle port at time zero
  initial begin
    regAccess = '0;
  end

  // One write: strobe up for one edge, then address and data scrambled
  task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    regAccess <= '{wrStb: 1'b1, rdStb: 1'b0, addr: addr, wrData: data};
    @(posedge mclk);
    regAccess <= '{wrStb: 1'b0, rdStb: 1'b0, addr: ~addr, wrData: ~data};
  endtask

  // One read: answer taken one cycle after the strobe edge
  task automatic regRead(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge mclk);
    regAccess <= '{wrStb: 1'b0, rdStb: 1'b1, addr: addr, wrData: 8'h00};
    @(posedge mclk);
    regAccess <= '{wrStb: 1'b0, rdStb: 1'b0, addr: ~addr, wrData: 8'hff};
    #1;
    valid = rdValid;
    data = rdData;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Top level bench
// ----------------------------------------
module tb;
  import charger_irq_pkg::*;
  localparam int PULSE = 4; // Short pulse for simulation
  logic mclk, rst, regResetCmd, rdValid, irqN;
  reg_access_type regAccess;
  fault_cond_type faultCondPin;
  charger_event_type chargerEvent;
  logic [7:0] rdData, seen, lows;
  logic valid;
  int failures, samples_checked;
  int flagBit [5] = '{SYS_SHORT_BIT, SYS_OVP_BIT, REV_OVP_BIT, REV_UVP_BIT, THERM_SHUT_BIT};

  // Free running clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  charger_irq_ctrl #(.PULSE_CYCLES(PULSE)) dut_u (
    .mclk(mclk),
    .rst(rst),
    .regResetCmd(regResetCmd),
    .regAccess(regAccess),
    .faultCondPin(faultCondPin),
    .chargerEvent(chargerEvent),
    .rdData(rdData),
    .rdValid(rdValid),
    .irqN(irqN)
  );

  host_model hostU (
    .mclk(mclk),
    .regAccess(regAccess),
    .rdData(rdData),
    .rdValid(rdValid)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compare and count
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read a register and compare answer and its valid flag
  task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
    hostU.regRead(addr, seen, valid);
    check("read valid", {7'h00, valid}, 8'h01);
    check("read data", seen, exp);
  endtask

  // Strobe one event bit, count low cycles of the interrupt line
  task automatic pulseCount(input int k, output logic [7:0] n);
    @(posedge mclk);
    chargerEvent <= 16'h0001 << k;
    @(posedge mclk);
    chargerEvent <= '0;
    n = 8'h00;
    repeat (16) begin
      @(posedge mclk);
      #1;
      if (irqN === 1'b0) n++;
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(40 * 20000);
    failures++;
    results;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    regResetCmd = 1'b0;
    faultCondPin = '0;
    chargerEvent = '0;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // Reset values
    readCheck(FAULT_FLAGS_SECONDARY_ADDR, 8'h00);
    readCheck(EVENT_MASK_FIRST_ADDR, 8'h00);
    readCheck(EVENT_MASK_SECOND_ADDR, 8'h00);
    // Read-only, reserved and unmapped places
    hostU.regWrite(FAULT_FLAGS_SECONDARY_ADDR, 8'hff);
    readCheck(FAULT_FLAGS_SECONDARY_ADDR, 8'h00);
    hostU.regWrite(EVENT_MASK_FIRST_ADDR, 8'hff);
    hostU.regWrite(EVENT_MASK_SECOND_ADDR, 8'hff);
    readCheck(EVENT_MASK_FIRST_ADDR, 8'hff);
    readCheck(EVENT_MASK_SECOND_ADDR, 8'hd7);
    readCheck(8'h2a, 8'h00);
    // Register reset command clears both masks
    @(posedge mclk);
    regResetCmd <= 1'b1;
    @(posedge mclk);
    regResetCmd <= 1'b0;
    readCheck(EVENT_MASK_FIRST_ADDR, 8'h00);
    readCheck(EVENT_MASK_SECOND_ADDR, 8'h00);
    // Each fault sets its own bit, read clears it
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      faultCondPin <= 5'b10000 >> i;
      repeat (5) @(posedge mclk);
      readCheck(FAULT_FLAGS_SECONDARY_ADDR, 8'h01 << flagBit[i]);
      readCheck(FAULT_FLAGS_SECONDARY_ADDR, 8'h00);
      @(posedge mclk);
      faultCondPin <= '0;
    end
    // Every event but reserved second-group bits 5 and 3: pulse when unmasked, none when masked
    for (int k = 0; k < 16; k++) begin
      if (k == 5 || k == 3) continue;
      pulseCount(k, lows);
      check("pulse width", lows, 8'(PULSE));
      hostU.regWrite(k >= 8 ? EVENT_MASK_FIRST_ADDR : EVENT_MASK_SECOND_ADDR, 8'h01 << (k % 8));
      pulseCount(k, lows);
      check("masked pulse", lows, 8'h00);
      hostU.regWrite(k >= 8 ? EVENT_MASK_FIRST_ADDR : EVENT_MASK_SECOND_ADDR, 8'h00);
    end
    results;
  end
endmodule
